// file: aio_pkg.sv
package aio_pkg;

  // channel counts and the internal time base
  localparam int NUM_IN        = 4;
  localparam int NUM_OUT       = 2;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS       = 1000000;                 // 1 ms tick
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;  // 250,000
  localparam int OUT_CYCLE_MS  = 1;                       // output refresh

  // register byte addresses, one aligned 32-bit word each
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_STATUS  = 8'h04;
  localparam logic [7:0] ADR_KICK    = 8'h08;
  localparam logic [7:0] ADR_IN_CFG  = 8'h10;  // + 4 x input channel
  localparam logic [7:0] ADR_IN_THR  = 8'h20;  // + 4 x input channel
  localparam logic [7:0] ADR_MEAS    = 8'h30;  // + 4 x input channel
  localparam logic [7:0] ADR_OUT_CFG = 8'h40;  // + 4 x output channel
  localparam logic [7:0] ADR_OUT_SET = 8'h48;  // + 4 x output channel
  localparam logic [7:0] ADR_CAL     = 8'h50;  // + 4 x output channel

  // control word fields
  localparam int CTRL_FAST   = 0;
  localparam int CTRL_INUSE  = 4;
  localparam int CTRL_OVFEN  = 8;
  localparam int CTRL_WIRING = 12;
  localparam int CTRL_WDOG   = 16;   // 8-bit watchdog time in ms, 0 = off

  // status word fields
  localparam int ST_OVF   = 0;
  localparam int ST_UNF   = 4;
  localparam int ST_UTOL  = 8;
  localparam int ST_LTOL  = 12;
  localparam int ST_OPEN  = 16;
  localparam int ST_SHORT = 18;
  localparam int ST_WDOG  = 20;
  localparam int ST_SCANS = 24;

  // input ranges
  localparam logic [2:0] IR_BIP10 = 3'h0;
  localparam logic [2:0] IR_U10   = 3'h1;
  localparam logic [2:0] IR_U5    = 3'h2;
  localparam logic [2:0] IR_1TO5  = 3'h3;
  localparam logic [2:0] IR_I020  = 3'h4;
  localparam logic [2:0] IR_I420  = 3'h5;

  // output ranges
  localparam logic [1:0] OR_V10  = 2'h0;
  localparam logic [1:0] OR_I020 = 2'h1;
  localparam logic [1:0] OR_I420 = 2'h2;

  // standardized scale and converter code limits
  localparam logic signed [31:0] FULL_SCALE  = 32'sh0000_2710; // 10,000
  localparam logic signed [31:0] LIVE_ZERO   = 32'sh0000_07D0; // 20 % of FS
  localparam logic signed [31:0] SPAN_80PCT  = 32'sh0000_3333; // 0.8 in Q14
  localparam logic signed [31:0] CODE_MAX    = 32'sh0000_1FFF; // 13 bits
  localparam int                 CAL_SHIFT   = 14;
  localparam logic [15:0]        CAL_GAIN_RST = 16'h346C;     // FS -> 8190

  typedef enum logic [1:0] {
    ST_SYNC = 2'b01,
    ST_CONV = 2'b10
  } aio_scan_t;

  // one converter word: polarity and 13-bit magnitude
  typedef struct packed {
    logic        sign;
    logic [12:0] mag;
  } aio_dac_t;

  // per-input limit results
  typedef struct packed {
    logic ovf;
    logic unf;
    logic utol;
    logic ltol;
  } aio_lim_t;

endpackage : aio_pkg

// file: aio_scan_monitor.sv
`timescale 1ns/1ns
// Operation
// - fixed mode scans all four inputs in a constant 5 ms cycle
// - reduced mode scans in-use inputs only: 1 ms plus 1 ms each
// - configured mode bit selects fixed or reduced scan timing
// - scan runs free of the host; host reads latest value anytime
// - tolerance flags are always computed, regardless of overflow enable
// - each input checked between lower and upper threshold of range
// - each input selects one of six ranges individually
// - each output selects +/-10 V, 0-20 mA or 4-20 mA
// - voltage or current conditioning chosen by software configuration
// - 4-20 mA output reports open loop at any set point
// - 0-20 mA output reports open loop only with nonzero set point
// - open loop errors only when wiring check is enabled
// - voltage output reports shorts and overloads as channel errors
// - both outputs refresh on a shared 1 ms cycle
// - output codes are 13-bit magnitude plus sign, rescaled automatically
// - factory gain and offset applied when building converter codes
// - host writes configuration and set points, device applies them
// - module status returns range overflow results to the host
// - above upper threshold is overflow, below lower is underflow
module aio_scan_monitor #(
  parameter int TICK_CYCLES = aio_pkg::TICK_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  output logic                      adcStart,
  output logic      [1:0]           adcChan,
  input  wire logic                 adcValid,
  input  wire logic signed [15:0]   adcData,
  output logic      [3:0]           inCurrentSel,
  output logic      [1:0]           outCurrentSel,
  output logic                      dacLoad,
  output aio_pkg::aio_dac_t [1:0]   dacCode,
  input  wire logic [1:0]           openSense,
  input  wire logic [1:0]           shortSense
);

  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  logic [TW-1:0]    tickCntQ;
  logic             tickQ;
  logic [31:0]      ctrlQ;
  logic [2:0]       inRangeQ [aio_pkg::NUM_IN];
  logic [31:0]      inThrQ   [aio_pkg::NUM_IN];
  logic [15:0]      measQ    [aio_pkg::NUM_IN];
  logic [31:0]      outCfgQ  [aio_pkg::NUM_OUT];
  logic [15:0]      outSetQ  [aio_pkg::NUM_OUT];
  logic [31:0]      calQ     [aio_pkg::NUM_OUT];
  aio_pkg::aio_lim_t limit   [aio_pkg::NUM_IN];
  aio_pkg::aio_dac_t codeD   [aio_pkg::NUM_OUT];
  aio_pkg::aio_scan_t scanQ;
  logic [1:0]       chanQ;
  logic [7:0]       scanCntQ;
  logic [7:0]       wdogCntQ;
  logic             wdogFaultQ;
  logic [1:0]       openMetaQ, openSyncQ, shortMetaQ, shortSyncQ;
  logic [1:0]       openErr, shortErr;
  logic             wrStb, rdStb, kick;
  logic [3:0]       scanMask;
  logic [2:0]       firstCh, nextCh;
  logic [31:0]      statusWord, rdData;

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge

  // next scanned channel at or after start; bit 2 set means none left
  function automatic logic [2:0] pick(input logic [3:0] mask,
                                      input logic [2:0] start);
    logic [2:0] r;
    r = 3'h4;
    for (int c = 3; c >= 0; c--) begin
      if (mask[c] && (3'(c) >= start)) r = 3'(c);
    end
    return r;
  endfunction : pick

  // single 1 ms time base shared by scan, outputs and watchdog
  always_ff @(posedge clock) begin
    if (sys_rst || tickCntQ == TICK_LAST) begin
      tickCntQ <= '0;
    end else begin
      tickCntQ <= tickCntQ + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) tickQ <= 1'b0;
    else tickQ <= (tickCntQ == TICK_LAST);
  end

  // wishbone classic: one wait state, ack drops after one cycle
  assign wrStb = cyc_i && stb_i && !ack_o && we_i;
  assign rdStb = cyc_i && stb_i && !ack_o && !we_i;

  always_ff @(posedge clock) begin
    if (sys_rst) ack_o <= 1'b0;
    else ack_o <= cyc_i && stb_i && !ack_o;
  end

  // control word: mode, in-use, overflow enable, wiring check, watchdog
  always_ff @(posedge clock) begin
    if (sys_rst) ctrlQ <= '0;
    else if (wrStb && adr_i == aio_pkg::ADR_CTRL)
      ctrlQ <= merge(ctrlQ, dat_i, sel_i);
  end

  // per-channel configuration written by the host
  for (genvar i = 0; i < aio_pkg::NUM_IN; i++) begin : g_incfg
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        inRangeQ[i] <= aio_pkg::IR_BIP10;
        inThrQ[i]   <= {16'h2AF8, 16'hD508};  // +11,000 / -11,000
      end else if (wrStb) begin
        if (adr_i == aio_pkg::ADR_IN_CFG + 8'(4 * i) && sel_i[0])
          inRangeQ[i] <= dat_i[2:0];
        if (adr_i == aio_pkg::ADR_IN_THR + 8'(4 * i))
          inThrQ[i] <= merge(inThrQ[i], dat_i, sel_i);
      end
    end
  end

  for (genvar o = 0; o < aio_pkg::NUM_OUT; o++) begin : g_outcfg
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        outCfgQ[o] <= '0;
        outSetQ[o] <= '0;
        calQ[o]    <= {16'h0000, aio_pkg::CAL_GAIN_RST};
      end else if (wrStb) begin
        if (adr_i == aio_pkg::ADR_OUT_CFG + 8'(4 * o))
          outCfgQ[o] <= merge(outCfgQ[o], dat_i, sel_i);
        if (adr_i == aio_pkg::ADR_OUT_SET + 8'(4 * o))
          outSetQ[o] <= merge({16'h0000, outSetQ[o]}, dat_i,
                              sel_i) [15:0];
        if (adr_i == aio_pkg::ADR_CAL + 8'(4 * o))
          calQ[o] <= merge(calQ[o], dat_i, sel_i);
      end
    end
  end

  // scan plan: fixed mode walks all four, reduced mode only in-use ones
  assign scanMask = ctrlQ[aio_pkg::CTRL_FAST]
                  ? ctrlQ[aio_pkg::CTRL_INUSE +: 4] : 4'hF;
  assign firstCh  = pick(scanMask, 3'h0);
  assign nextCh   = pick(scanMask, {1'b0, chanQ} + 3'h1);

  // one overhead ms, then one ms per scanned channel: 5 ms when fixed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scanQ    <= aio_pkg::ST_SYNC;
      chanQ    <= '0;
      scanCntQ <= '0;
    end else if (tickQ) begin
      case (scanQ)
        aio_pkg::ST_SYNC: begin
          if (!firstCh[2]) begin
            scanQ <= aio_pkg::ST_CONV;
            chanQ <= firstCh[1:0];
          end
          scanCntQ <= scanCntQ + 8'h01;
        end
        aio_pkg::ST_CONV: begin
          if (nextCh[2]) begin
            scanQ <= aio_pkg::ST_SYNC;
          end else begin
            chanQ <= nextCh[1:0];
          end
        end
        default: scanQ <= aio_pkg::ST_SYNC;
      endcase
    end
  end

  // conversion request at each ms spent on a channel
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      adcStart <= 1'b0;
      adcChan  <= '0;
    end else begin
      adcStart <= tickQ && (scanQ == aio_pkg::ST_SYNC ? !firstCh[2]
                                                      : !nextCh[2]);
      // channel moves only with a start, so it names the last conversion
      if (tickQ && (scanQ == aio_pkg::ST_SYNC ? !firstCh[2] : !nextCh[2]))
        adcChan <= (scanQ == aio_pkg::ST_SYNC) ? firstCh[1:0]
                                               : nextCh[1:0];
    end
  end

  // latest value held per channel; host samples it at its own pace
  for (genvar i = 0; i < aio_pkg::NUM_IN; i++) begin : g_meas
    always_ff @(posedge clock) begin
      if (sys_rst) measQ[i] <= '0;
      else if (adcValid && adcChan == 2'(i))
        measQ[i] <= adcData;
    end
  end

  // limit checks, run on every input all the time
  for (genvar i = 0; i < aio_pkg::NUM_IN; i++) begin : g_lim
    logic signed [15:0] m, lo, hi, nomMin;
    assign m      = measQ[i];
    assign lo     = inThrQ[i][15:0];
    assign hi     = inThrQ[i][31:16];
    assign nomMin = (inRangeQ[i] == aio_pkg::IR_BIP10)
                  ? -aio_pkg::FULL_SCALE[15:0] : 16'sh0000;
    assign limit[i].ovf  = m > hi;
    assign limit[i].unf  = m < lo;
    // signed compare, or negative readings would land in the upper zone
    assign limit[i].utol = m > signed'(aio_pkg::FULL_SCALE[15:0])
                        && !limit[i].ovf;
    assign limit[i].ltol = m < nomMin && !limit[i].unf;
  end

  // fault pins come from the analog side: two flops first
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      openMetaQ  <= '0;
      openSyncQ  <= '0;
      shortMetaQ <= '0;
      shortSyncQ <= '0;
    end else begin
      openMetaQ  <= openSense;
      openSyncQ  <= openMetaQ;
      shortMetaQ <= shortSense;
      shortSyncQ <= shortMetaQ;
    end
  end

  // output wiring errors by range
  for (genvar o = 0; o < aio_pkg::NUM_OUT; o++) begin : g_wire
    logic [1:0] rng;
    assign rng = outCfgQ[o][1:0];
    assign openErr[o] = ctrlQ[aio_pkg::CTRL_WIRING] && openSyncQ[o]
                     && (rng == aio_pkg::OR_I420
                     || (rng == aio_pkg::OR_I020 && outSetQ[o] != '0));
    assign shortErr[o] = (rng == aio_pkg::OR_V10 || rng == 2'h3)
                      && shortSyncQ[o];
  end

  // watchdog: any set point or kick write restarts it
  assign kick = wrStb && (adr_i == aio_pkg::ADR_KICK
             || adr_i == aio_pkg::ADR_OUT_SET
             || adr_i == aio_pkg::ADR_OUT_SET + 8'h04);

  always_ff @(posedge clock) begin
    if (sys_rst || kick) wdogCntQ <= '0;
    else if (tickQ && wdogCntQ != 8'hFF) wdogCntQ <= wdogCntQ + 8'h01;
  end

  // sticky fault; a new expiry wins over a clearing write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdogFaultQ <= 1'b0;
    end else if (ctrlQ[aio_pkg::CTRL_WDOG +: 8] != 8'h00
              && wdogCntQ >= ctrlQ[aio_pkg::CTRL_WDOG +: 8]) begin
      wdogFaultQ <= 1'b1;
    end else if (wrStb && adr_i == aio_pkg::ADR_STATUS && sel_i[2]
              && dat_i[aio_pkg::ST_WDOG]) begin
      wdogFaultQ <= 1'b0;
    end
  end

  // set point to converter code: rescale, calibrate, clamp to 13 bits
  for (genvar o = 0; o < aio_pkg::NUM_OUT; o++) begin : g_code
    always_comb begin
      logic signed [31:0] sp, eff, mag, cal;
      logic        [1:0]  rng;
      rng = outCfgQ[o][1:0];
      sp  = wdogFaultQ ? 32'(signed'(outCfgQ[o][31:16]))
                       : 32'(signed'(outSetQ[o]));
      if (rng != aio_pkg::OR_V10 && rng != 2'h3 && sp < 0) sp = '0;
      if (rng == aio_pkg::OR_I420)
        eff = aio_pkg::LIVE_ZERO
            + ((sp * aio_pkg::SPAN_80PCT) >>> aio_pkg::CAL_SHIFT);
      else
        eff = sp;
      mag = (eff < 0) ? -eff : eff;
      cal = ((mag * 32'(calQ[o][15:0])) >>> aio_pkg::CAL_SHIFT)
          + 32'(signed'(calQ[o][31:16]));
      if (cal < 0) cal = '0;
      if (cal > aio_pkg::CODE_MAX) cal = aio_pkg::CODE_MAX;
      codeD[o].sign = (eff < 0);
      codeD[o].mag  = cal[12:0];
    end
  end

  // both outputs reloaded together on each ms tick
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dacLoad <= 1'b0;
      dacCode <= '0;
    end else begin
      dacLoad <= tickQ;
      if (tickQ) begin
        dacCode[0] <= codeD[0];
        dacCode[1] <= codeD[1];
      end
    end
  end

  // conditioning selects follow configured ranges, no straps
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      inCurrentSel  <= '0;
      outCurrentSel <= '0;
    end else begin
      for (int i = 0; i < aio_pkg::NUM_IN; i++)
        inCurrentSel[i] <= inRangeQ[i] == aio_pkg::IR_I020
                        || inRangeQ[i] == aio_pkg::IR_I420;
      for (int o = 0; o < aio_pkg::NUM_OUT; o++)
        outCurrentSel[o] <= outCfgQ[o][1:0] == aio_pkg::OR_I020
                         || outCfgQ[o][1:0] == aio_pkg::OR_I420;
    end
  end

  // status word; overflow bits gated per channel, tolerance never gated
  always_comb begin
    statusWord = '0;
    for (int i = 0; i < aio_pkg::NUM_IN; i++) begin
      statusWord[aio_pkg::ST_OVF + i] = limit[i].ovf
        && ctrlQ[aio_pkg::CTRL_OVFEN + i];
      statusWord[aio_pkg::ST_UNF + i] = limit[i].unf
        && ctrlQ[aio_pkg::CTRL_OVFEN + i];
      statusWord[aio_pkg::ST_UTOL + i] = limit[i].utol;
      statusWord[aio_pkg::ST_LTOL + i] = limit[i].ltol;
    end
    statusWord[aio_pkg::ST_OPEN +: 2]  = openErr;
    statusWord[aio_pkg::ST_SHORT +: 2] = shortErr;
    statusWord[aio_pkg::ST_WDOG]       = wdogFaultQ;
    statusWord[aio_pkg::ST_SCANS +: 8] = scanCntQ;
  end

  // read decode; unmapped addresses read zero
  always_comb begin
    rdData = '0;
    case (adr_i)
      aio_pkg::ADR_CTRL:   rdData = ctrlQ;
      aio_pkg::ADR_STATUS: rdData = statusWord;
      default: begin
        for (int i = 0; i < aio_pkg::NUM_IN; i++) begin
          if (adr_i == aio_pkg::ADR_IN_CFG + 8'(4 * i))
            rdData = {29'h0, inRangeQ[i]};
          if (adr_i == aio_pkg::ADR_IN_THR + 8'(4 * i))
            rdData = inThrQ[i];
          if (adr_i == aio_pkg::ADR_MEAS + 8'(4 * i))
            rdData = {16'h0000, measQ[i]};
        end
        for (int o = 0; o < aio_pkg::NUM_OUT; o++) begin
          if (adr_i == aio_pkg::ADR_OUT_CFG + 8'(4 * o))
            rdData = outCfgQ[o];
          if (adr_i == aio_pkg::ADR_OUT_SET + 8'(4 * o))
            rdData = {16'h0000, outSetQ[o]};
          if (adr_i == aio_pkg::ADR_CAL + 8'(4 * o))
            rdData = calQ[o];
        end
      end
    endcase
  end

  // read data held from a flop so it is stable with ack
  always_ff @(posedge clock) begin
    if (sys_rst) dat_o <= '0;
    else if (rdStb) dat_o <= rdData;
  end

endmodule : aio_scan_monitor

// file: aio_props.sv
`timescale 1ns/1ns
module aio_props #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic                   clock,
  input wire logic                   sys_rst,
  input wire logic                   cyc_i,
  input wire logic                   stb_i,
  input wire logic                   ack_o,
  input wire logic                   adcStart,
  input wire logic [1:0]             adcChan,
  input wire logic                   dacLoad,
  input wire aio_pkg::aio_dac_t [1:0] dacCode
);
  localparam int TICK_M1 = TICK_CYCLES - 1;

  // all checks share the one clock and its reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // request seen by the slave, and the last conversion of a scan
  sequence reqTaken; cyc_i && stb_i && !ack_o; endsequence
  sequence lastScan; adcStart && adcChan == 2'h3; endsequence
  sequence idleTick; dacLoad && !adcStart; endsequence

  a_ack_next: assert property (reqTaken |=> ack_o)
    else $error("request not answered");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
    else $error("ack without a request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_start_tick: assert property (adcStart |-> dacLoad)
    else $error("conversion start off the tick");
  a_load_period: assert property (dacLoad |=> !dacLoad ##TICK_M1 dacLoad)
    else $error("output refresh period wrong");
  a_code_hold: assert property (!dacLoad |-> $stable(dacCode))
    else $error("output code moved between loads");
  a_chan_hold: assert property (!adcStart |-> $stable(adcChan))
    else $error("channel moved without a start");
  a_sync_gap: assert property (lastScan |-> ##TICK_CYCLES idleTick)
    else $error("no overhead slot after last channel");
endmodule : aio_props

bind aio_scan_monitor aio_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .clock(clock), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .adcStart(adcStart), .adcChan(adcChan),
  .dacLoad(dacLoad), .dacCode(dacCode));

// file: aio_adc_model.sv
`timescale 1ns/1ns
module aio_adc_model (
  input wire logic              clock,
  input wire logic              slow,
  input wire logic              adcStart,
  input wire logic [1:0]        adcChan,
  input wire logic [3:0][15:0]  chVal,
  output logic                  adcValid,
  output logic signed [15:0]    adcData
);
  logic [3:0]  waitQ = 4'h0;
  logic [15:0] lastQ = 16'h0000;

  // answers a start after 3 or 12 cycles; data is garbage outside valid
  always @(posedge clock) begin
    adcValid <= 1'b0;
    adcData  <= ~lastQ;
    if (adcStart) begin
      waitQ <= slow ? 4'hC : 4'h3;
    end else if (waitQ != 4'h0) begin
      waitQ <= waitQ - 4'h1;
      if (waitQ == 4'h1) begin
        adcValid <= 1'b1;
        adcData  <= chVal[adcChan];
        lastQ    <= chVal[adcChan];
      end
    end
  end
endmodule : aio_adc_model

// file: analog_io_scan_monitor_test.sv
`timescale 1ns/1ns
module analog_io_scan_monitor_test;
  localparam int TICK = 20;
  logic                     clock, sysRst, cyc, stb, we, ack, slow;
  logic [7:0]               adr;
  logic [3:0]               sel, inCurSel;
  logic [31:0]              datW, datR, r;
  logic                     adcStart, adcValid, dacLoad;
  logic [1:0]               adcChan, outCurSel, openSense, shortSense;
  logic signed [15:0]       adcData;
  logic [3:0][15:0]         chVal;
  aio_pkg::aio_dac_t [1:0]  dacCode;
  int                       fails, nCompared, cycles, gap, n, e0, m1;
  logic [7:0]               seq;

  aio_scan_monitor #(.TICK_CYCLES(TICK)) i_dut (
    .clock(clock), .sys_rst(sysRst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
    .adcStart(adcStart), .adcChan(adcChan), .adcValid(adcValid),
    .adcData(adcData), .inCurrentSel(inCurSel), .outCurrentSel(outCurSel),
    .dacLoad(dacLoad), .dacCode(dacCode), .openSense(openSense),
    .shortSense(shortSense));
  aio_adc_model i_adc (.clock(clock), .slow(slow), .adcStart(adcStart),
    .adcChan(adcChan), .chVal(chVal), .adcValid(adcValid), .adcData(adcData));

  task testDone;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : testDone

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datW <= d; sel <= s;
    do @(posedge clock); while (ack !== 1'b1);
    r = datR;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(r, e, "register read");
  endtask : rdChk

  task automatic waitLoad;
    do @(posedge clock); while (dacLoad !== 1'b1);
  endtask : waitLoad

  // one scan cycle from a channel 0 start to the next
  task automatic scanPeriod;
    int t0;
    do @(posedge clock); while (!(adcStart === 1'b1 && adcChan === 2'h0));
    t0 = cycles; seq = 8'h00; n = 0;
    do begin
      @(posedge clock);
      if (adcStart === 1'b1 && adcChan !== 2'h0) begin
        seq[2*n +: 2] = adcChan;
        n++;
      end
    end while (!(adcStart === 1'b1 && adcChan === 2'h0));
    gap = cycles - t0;
  endtask : scanPeriod

  task automatic testReset;
    rdChk(aio_pkg::ADR_IN_THR, 32'h2AF8D508);
    rdChk(aio_pkg::ADR_CAL, 32'h0000346C);
    rdChk(aio_pkg::ADR_CTRL, 32'h00000000);
    rdChk(8'hFC, 32'h00000000);
  endtask : testReset

  task automatic testScan;
    scanPeriod();
    chk(gap, 5 * TICK, "fixed period");
    chk({n[7:0], seq}, 16'h0339, "fixed order");
    slow <= 1'b1;
    wr(aio_pkg::ADR_CTRL, 32'h00000051);
    scanPeriod();
    scanPeriod();
    chk(gap, 3 * TICK, "reduced period");
    chk({n[7:0], seq}, 16'h0102, "reduced order");
    slow <= 1'b0;
  endtask : testScan

  task automatic testLimits;
    for (int i = 0; i < 6; i++) begin
      wr(aio_pkg::ADR_IN_CFG + 8'h04, 32'(i));
      @(posedge clock);
      chk(inCurSel[1], i >= 4, "input conditioning");
    end
    wr(aio_pkg::ADR_IN_CFG + 8'h04, 32'h00000000);
    wr(aio_pkg::ADR_IN_CFG + 8'h0C, {29'h0, aio_pkg::IR_U10});
    wr(aio_pkg::ADR_CTRL, 32'h00000500);
    repeat (12 * TICK) @(posedge clock);
    wb(1'b0, aio_pkg::ADR_STATUS, 32'h0, 4'hF);
    chk(r[15:0], 16'h8241, "limit flags");
    wr(aio_pkg::ADR_MEAS, 32'h00000000);
    wb(1'b0, aio_pkg::ADR_MEAS, 32'h0, 4'hF);
    chk(r[15:0], 16'h2EE0, "measurement");
  endtask : testLimits

  task automatic testOutputs;
    e0 = (5000 * int'(aio_pkg::CAL_GAIN_RST)) >>> aio_pkg::CAL_SHIFT;
    m1 = aio_pkg::LIVE_ZERO
       + ((aio_pkg::FULL_SCALE * aio_pkg::SPAN_80PCT) >>> aio_pkg::CAL_SHIFT);
    m1 = (m1 * int'(aio_pkg::CAL_GAIN_RST)) >>> aio_pkg::CAL_SHIFT;
    wr(aio_pkg::ADR_OUT_CFG + 8'h04, {30'h0, aio_pkg::OR_I420});
    wr(aio_pkg::ADR_OUT_SET, 32'h0000EC78);
    wr(aio_pkg::ADR_OUT_SET + 8'h04, 32'h00002710);
    gap = cycles;
    waitLoad();
    chk(cycles - gap <= TICK + 1, 1'b1, "output latency");
    chk(dacCode[0], {1'b1, 13'(e0)}, "voltage code");
    chk(dacCode[1], {1'b0, 13'(m1)}, "current code");
    chk(outCurSel, 2'b10, "output conditioning");
    wr(aio_pkg::ADR_CAL, 32'h00104000);
    waitLoad();
    chk(dacCode[0], 14'h3398, "calibrated code");
  endtask : testOutputs

  task automatic testFaults;
    shortSense <= 2'b01;
    repeat (4) @(posedge clock);
    wb(1'b0, aio_pkg::ADR_STATUS, 32'h0, 4'hF);
    chk(r[19:16], 4'h4, "short flag");
    shortSense <= 2'b00;
    openSense <= 2'b11;
    wr(aio_pkg::ADR_OUT_CFG, {30'h0, aio_pkg::OR_I020});
    wr(aio_pkg::ADR_OUT_SET, 32'h00000000);
    wb(1'b0, aio_pkg::ADR_STATUS, 32'h0, 4'hF);
    chk(r[17:16], 2'b00, "open, check off");
    wr(aio_pkg::ADR_CTRL, 32'h00001500);
    wb(1'b0, aio_pkg::ADR_STATUS, 32'h0, 4'hF);
    chk(r[17:16], 2'b10, "open, zero set point");
    wr(aio_pkg::ADR_OUT_SET, 32'h00000064);
    wb(1'b0, aio_pkg::ADR_STATUS, 32'h0, 4'hF);
    chk(r[17:16], 2'b11, "open, live set point");
    openSense <= 2'b00;
  endtask : testFaults

  task automatic testWatchdog;
    wr(aio_pkg::ADR_OUT_CFG, 32'h03E80000);
    wr(aio_pkg::ADR_CTRL, 32'h00020000);
    repeat (4 * TICK) @(posedge clock);
    waitLoad();
    chk(dacCode[0], 14'h03F8, "fallback code");
    wb(1'b0, aio_pkg::ADR_STATUS, 32'h0, 4'hF);
    chk(r[20], 1'b1, "watchdog flag");
    wr(aio_pkg::ADR_CTRL, 32'h00000000);
    wb(1'b1, aio_pkg::ADR_STATUS, 32'h00100000, 4'h4);
    wb(1'b0, aio_pkg::ADR_STATUS, 32'h0, 4'hF);
    chk(r[20], 1'b0, "watchdog cleared");
  endtask : testWatchdog

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      testDone();
    end
  end

  initial begin
    {cyc, stb, we, slow, adr, sel, datW} = '0;
    {openSense, shortSense, fails, nCompared, cycles} = '0;
    chVal = {16'hFE0C, 16'hD120, 16'h2904, 16'h2EE0};
    sysRst = 1'b1;
    repeat (8) @(posedge clock);
    sysRst <= 1'b0;
    testReset();
    testScan();
    testLimits();
    testOutputs();
    testFaults();
    testWatchdog();
    testDone();
  end
endmodule : analog_io_scan_monitor_test
